// File: hdl/adf_pkg.sv
/*
  Package for the gain-control decay, ADC digital-path and bypass-switch register slice.
  Assumes an internal register port of the codec's control-bus engine on the same clock.
*/
package adf_pkg;
  // ==========================================================
  // Register map (page 0)
  localparam logic [6:0] ADF_OFS_DECAY = 7'h6a;
  localparam logic [6:0] ADF_OFS_PATH = 7'h6b;
  localparam logic [6:0] ADF_OFS_BYPASS = 7'h6c;
  localparam logic [7:0] ADF_RST_VAL = 8'h00;
  // ==========================================================
  // Field positions
  localparam int ADF_DEC_SEL_BIT = 7;
  localparam int ADF_DEC_BASE_LSB = 5;
  localparam int ADF_DEC_MULT_LSB = 2;
  localparam int ADF_PATH_HPL_BIT = 7;
  localparam int ADF_PATH_HPR_BIT = 6;
  localparam int ADF_PATH_PRG_BIT = 3;
  localparam int ADF_PATH_DIS_BIT = 2;
  localparam int ADF_PATH_ERR_BIT = 0;
  // Writable masks; reserved bits read as zero
  localparam logic [7:0] ADF_DECAY_WMASK = 8'hfc;
  localparam logic [7:0] ADF_PATH_WMASK = 8'hcc;
  localparam logic [7:0] ADF_BYPASS_WMASK = 8'h5f;
  // ==========================================================
  // Decay times in milliseconds
  localparam logic [15:0] ADF_BASE_MS0 = 16'h0032;
  localparam logic [15:0] ADF_BASE_MS1 = 16'h0096;
  localparam logic [15:0] ADF_BASE_MS2 = 16'h00fa;
  localparam logic [15:0] ADF_BASE_MS3 = 16'h015e;
  // Decimation ratio in half steps (code = 2*ratio); caps in ms
  localparam logic [15:0] ADF_CAP_R1 = 16'h0fa0;
  localparam logic [15:0] ADF_CAP_R15 = 16'h15e0;
  localparam logic [15:0] ADF_CAP_R2 = 16'h1f40;
  localparam logic [15:0] ADF_CAP_R25 = 16'h2580;
  localparam logic [15:0] ADF_CAP_R3 = 16'h2bc0;
  localparam logic [15:0] ADF_CAP_R4 = 16'h3e80;
  localparam logic [15:0] ADF_CAP_R5 = 16'h4b00;
  localparam logic [15:0] ADF_CAP_R55 = 16'h5780;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } adf_req_t;

  typedef struct packed {
    logic hp_left_prog;
    logic hp_right_prog;
    logic prog_filter_on;
    logic err_detect_en;
  } adf_path_t;

  typedef struct packed {
    logic [1:0] right_plus;
    logic [1:0] left_plus;
    logic [1:0] left_minus;
  } adf_bypass_t;
endpackage

// File: hdl/adf_regs.sv
/*
  Register slice: right decay override, ADC path and bus-error control, bypass switches.
  Assumes the bus engine presents one-cycle strobes on clk and a page-select level.
*/
// Behaviour
// - Select bit picks legacy or own decay
// - Baseline code gives 50 to 350 ms
// - Multiplier code scales baseline by power two
// - Decay capped by decimation ratio
// - Bit7 picks left highpass coefficient set
// - Bit6 picks right highpass coefficient set
// - Bit3 with DACs off inserts filter
// - Disable bit turns off bus-error detection
// - Error flag sets, clears on read
// - Bits 6,4 route right plus inputs
// - Bits 2,0 route left plus inputs
// - Bits 3,1 route left minus inputs
// - Access only while page zero active
module adf_regs
  import adf_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input adf_pkg::adf_req_t req,
  input wire logic page_sel,
  input wire logic bus_err_event,
  input wire logic dacs_powered_down,
  input wire logic [15:0] legacy_decay_ms,
  input wire logic [3:0] adc_decimation_ratio,
  output logic [7:0] rdata,
  output logic [15:0] decay_ms,
  output adf_pkg::adf_path_t path,
  output adf_pkg::adf_bypass_t bypass
);
  import adf_pkg::*;

  // ==========================================================
  // Decode
  logic [7:0] decay_reg, decay_next;
  logic [7:0] path_reg, path_next;
  logic [7:0] bypass_reg, bypass_next;
  logic err_reg, err_next;
  logic [7:0] rdata_next;

  wire page0 = ~page_sel;
  wire hit_decay = page0 && req.addr == ADF_OFS_DECAY;
  wire hit_path = page0 && req.addr == ADF_OFS_PATH;
  wire hit_bypass = page0 && req.addr == ADF_OFS_BYPASS;
  wire wr_decay = req.wr && hit_decay;
  wire wr_path = req.wr && hit_path;
  wire wr_bypass = req.wr && hit_bypass;
  wire rd_path = req.rd && hit_path;
  wire det_en = ~path_reg[ADF_PATH_DIS_BIT];

  // Reserved bits are masked off, so they always read zero
  assign decay_next = wr_decay ? (req.wdata & ADF_DECAY_WMASK) : decay_reg;
  assign path_next = wr_path ? (req.wdata & ADF_PATH_WMASK) : path_reg;
  assign bypass_next = wr_bypass ? (req.wdata & ADF_BYPASS_WMASK) : bypass_reg;
  // New event wins over the read clear
  assign err_next = (det_en && bus_err_event) ? 1'b1 : (rd_path ? 1'b0 : err_reg);

  wire [7:0] path_rd = path_reg | {7'h00, err_reg};
  assign rdata_next = !req.rd ? rdata :
    hit_decay ? decay_reg :
    hit_path ? path_rd :
    hit_bypass ? bypass_reg : 8'h00;

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      decay_reg <= ADF_RST_VAL;
      path_reg <= ADF_RST_VAL;
      bypass_reg <= ADF_RST_VAL;
      err_reg <= 1'b0;
      rdata <= ADF_RST_VAL;
    end else begin
      decay_reg <= decay_next;
      path_reg <= path_next;
      bypass_reg <= bypass_next;
      err_reg <= err_next;
      rdata <= rdata_next;
    end
  end

  // ==========================================================
  // Decay time
  wire [1:0] base_code = decay_reg[ADF_DEC_BASE_LSB +: 2];
  wire [2:0] mult_code = decay_reg[ADF_DEC_MULT_LSB +: 3];
  wire [15:0] base_ms = base_code == 2'h0 ? ADF_BASE_MS0 :
    base_code == 2'h1 ? ADF_BASE_MS1 :
    base_code == 2'h2 ? ADF_BASE_MS2 : ADF_BASE_MS3;
  wire [22:0] own_ms = {7'h00, base_ms} << mult_code;
  wire [22:0] sel_ms = decay_reg[ADF_DEC_SEL_BIT] ? own_ms : {7'h00, legacy_decay_ms};
  logic [15:0] cap_ms;
  always_comb begin
    unique case (adc_decimation_ratio)
      4'h2: cap_ms = ADF_CAP_R1;
      4'h3: cap_ms = ADF_CAP_R15;
      4'h4: cap_ms = ADF_CAP_R2;
      4'h5: cap_ms = ADF_CAP_R25;
      4'h6, 4'h7: cap_ms = ADF_CAP_R3;
      4'h8, 4'h9: cap_ms = ADF_CAP_R4;
      4'ha: cap_ms = ADF_CAP_R5;
      default: cap_ms = ADF_CAP_R55;
    endcase
  end
  logic [15:0] decay_ms_next;
  assign decay_ms_next = sel_ms > {7'h00, cap_ms} ? cap_ms : sel_ms[15:0];

  // ==========================================================
  // Outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      decay_ms <= 16'h0000;
      path <= '0;
      bypass <= '0;
    end else begin
      decay_ms <= decay_ms_next;
      path.hp_left_prog <= path_reg[ADF_PATH_HPL_BIT];
      path.hp_right_prog <= path_reg[ADF_PATH_HPR_BIT];
      path.prog_filter_on <= path_reg[ADF_PATH_PRG_BIT] & dacs_powered_down;
      path.err_detect_en <= det_en;
      bypass.right_plus <= {bypass_reg[6], bypass_reg[4]};
      bypass.left_plus <= {bypass_reg[2], bypass_reg[0]};
      bypass.left_minus <= {bypass_reg[3], bypass_reg[1]};
    end
  end

  // ==========================================================
  // Checks
  a_err_set: assert property (@(posedge clk) disable iff (sys_rst)
    det_en && bus_err_event |=> err_reg) else $error("error flag not set");
  a_err_clear: assert property (@(posedge clk) disable iff (sys_rst)
    rd_path && !bus_err_event |=> !err_reg) else $error("flag not cleared");
  a_err_disabled: assert property (@(posedge clk) disable iff (sys_rst)
    !det_en && !err_reg |=> !err_reg) else $error("flag set while off");
  a_page_block: assert property (@(posedge clk) disable iff (sys_rst)
    page_sel |=> $stable(bypass_reg) && $stable(decay_reg)) else $error("page1 write");
  a_write_back: assert property (@(posedge clk) disable iff (sys_rst)
    wr_bypass |=> bypass_reg == $past(req.wdata & ADF_BYPASS_WMASK)) else $error("no store");
  a_decay_cap: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> decay_ms <= $past(cap_ms)) else $error("cap exceeded");
  a_legacy_sel: assert property (@(posedge clk) disable iff (sys_rst)
    !decay_reg[7] && legacy_decay_ms <= cap_ms |=> decay_ms == $past(legacy_decay_ms))
    else $error("legacy decay wrong");
  a_base_min: assert property (@(posedge clk) disable iff (sys_rst)
    decay_reg[7:2] == 6'h20 |=> decay_ms == ADF_BASE_MS0) else $error("base wrong");
  a_filter_gate: assert property (@(posedge clk) disable iff (sys_rst)
    !dacs_powered_down |=> !path.prog_filter_on) else $error("filter inserted");
  a_right_route: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> bypass.right_plus == $past({bypass_reg[6], bypass_reg[4]}))
    else $error("right route");
  a_left_route: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> bypass.left_plus == $past({bypass_reg[2], bypass_reg[0]}))
    else $error("left route");
  a_minus_route: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> bypass.left_minus == $past({bypass_reg[3], bypass_reg[1]}))
    else $error("minus route");
  a_coef_sel: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> path.hp_left_prog == $past(path_reg[7]) && path.hp_right_prog == $past(path_reg[6]))
    else $error("coef select");
  a_mult_max: assert property (@(posedge clk) disable iff (sys_rst)
    decay_reg[7:2] == 6'h3f && adc_decimation_ratio == 4'hc |=> decay_ms == ADF_CAP_R55)
    else $error("mult wrong");

  c_err_read: cover property (@(posedge clk) err_reg && rd_path);
  c_own_decay: cover property (@(posedge clk) decay_reg[7] && decay_ms_next == cap_ms);
  c_filter: cover property (@(posedge clk) path.prog_filter_on);
  c_bypass: cover property (@(posedge clk) wr_bypass);
endmodule

// File: dv/adf_host.sv
/*
  Host model: issues register accesses to the slice and sets the active page.
  Assumes clk from the bench; requests launch just after a rising edge.
*/
module adf_host
  import adf_pkg::*;
(
  input wire logic clk,
  output adf_pkg::adf_req_t req,
  output logic page_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req = '0;
    page_sel = 1'b0;
  end
  // ==========================================
  // One-cycle access strobe
  task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic set_page(input logic p);
    @(posedge clk);
    page_sel <= p;
  endtask
endmodule

// File: dv/testbench.sv
/*
  Self-checking bench for the decay, ADC path and bypass register slice.
  Assumes the host model drives the register port.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import adf_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic bus_err_event = 1'b0;
  logic dacs_powered_down = 1'b0;
  logic [15:0] legacy_decay_ms = 16'h0123;
  logic [3:0] adc_decimation_ratio = 4'h2;
  adf_req_t req;
  logic page_sel;
  logic [7:0] rdata;
  logic [15:0] decay_ms;
  adf_path_t path;
  adf_bypass_t bypass;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  adf_host host (.clk(clk), .req(req), .page_sel(page_sel));
  adf_regs dut (.clk(clk), .sys_rst(sys_rst), .req(req), .page_sel(page_sel),
    .bus_err_event(bus_err_event), .dacs_powered_down(dacs_powered_down),
    .legacy_decay_ms(legacy_decay_ms), .adc_decimation_ratio(adc_decimation_ratio),
    .rdata(rdata), .decay_ms(decay_ms), .path(path), .bypass(bypass));
  // ==========================================
  // Access and compare helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    host.access(1'b0, a, 8'h00);
    #1;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.access(1'b1, a, d);
    @(posedge clk);
    #1;
  endtask
  task automatic pulse_err();
    @(posedge clk);
    bus_err_event <= 1'b1;
    @(posedge clk);
    bus_err_event <= 1'b0;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    rd(ADF_OFS_DECAY, 8'h00);
    rd(ADF_OFS_PATH, 8'h00);
    rd(ADF_OFS_BYPASS, 8'h00);
    chk({10'h000, bypass}, 16'h0000);
  endtask
  task automatic t_decay(input logic [3:0] ratio, input int cap);
    int base[4] = '{50, 150, 250, 350};
    int e;
    @(posedge clk);
    adc_decimation_ratio <= ratio;
    wr(ADF_OFS_DECAY, 8'h00);
    chk(decay_ms, legacy_decay_ms);
    for (int b = 0; b < 4; b++) begin
      for (int m = 0; m < 8; m++) begin
        e = base[b] << m;
        wr(ADF_OFS_DECAY, {1'b1, b[1:0], m[2:0], 2'b00});
        chk(decay_ms, 16'(e > cap ? cap : e));
      end
    end
    rd(ADF_OFS_DECAY, 8'hfc);
  endtask
  task automatic t_path();
    logic [7:0] v[4] = '{8'h80, 8'h40, 8'h08, 8'h04};
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      d = v[i % 4];
      @(posedge clk);
      dacs_powered_down <= i[2];
      wr(ADF_OFS_PATH, d);
      chk({12'h000, path}, {12'h000, d[7], d[6], d[3] & i[2], ~d[2]});
      rd(ADF_OFS_PATH, d);
    end
  endtask
  task automatic t_err();
    wr(ADF_OFS_PATH, 8'h00);
    pulse_err();
    rd(ADF_OFS_PATH, 8'h01);
    rd(ADF_OFS_PATH, 8'h00);
    wr(ADF_OFS_PATH, 8'h04);
    pulse_err();
    rd(ADF_OFS_PATH, 8'h04);
  endtask
  task automatic t_bypass();
    int pos[6] = '{6, 4, 2, 0, 3, 1};
    for (int i = 0; i < 6; i++) begin
      wr(ADF_OFS_BYPASS, 8'h01 << pos[i]);
      chk({10'h000, bypass}, 16'h0020 >> i);
    end
  endtask
  task automatic t_page();
    wr(ADF_OFS_BYPASS, 8'h10);
    host.set_page(1'b1);
    wr(ADF_OFS_BYPASS, 8'h01);
    chk({10'h000, bypass}, 16'h0010);
    rd(ADF_OFS_BYPASS, 8'h00);
    host.set_page(1'b0);
    rd(ADF_OFS_BYPASS, 8'h10);
    rd(7'h6d, 8'h00);
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_decay(4'h2, 4000);
    t_decay(4'hc, 22400);
    t_path();
    t_err();
    t_bypass();
    t_page();
    tally_and_finish();
  end
endmodule
